// *** core/cowl_pkg.sv ***
// Constants for the comparator output and window logic
package cowl_pkg;
  localparam logic [2:0] OFS_CTRLA   = 3'h0;
  localparam logic [2:0] OFS_CTRLB   = 3'h1;
  localparam logic [2:0] OFS_MUXCTRL = 3'h2;
  localparam logic [2:0] OFS_REF     = 3'h5;
  localparam logic [2:0] OFS_INTCTRL = 3'h6;
  localparam logic [2:0] OFS_STATUS  = 3'h7;
  // Control A fields
  localparam int B_EN     = 0;
  localparam int B_HYS    = 1;
  localparam int B_PWR    = 3;
  localparam int B_PADEN  = 6;
  localparam int B_STDBY  = 7;
  // Mux control fields
  localparam int B_NEG    = 0;
  localparam int B_POS    = 3;
  localparam int B_INIT   = 6;
  localparam int B_INV    = 7;
  // Interrupt control fields
  localparam int B_IEN    = 0;
  localparam int B_MODE   = 4;
  // Status fields
  localparam int B_IF     = 0;
  localparam int B_MATCH  = 4;
  localparam int B_WPOS   = 6;
  // Window partner codes
  localparam logic [1:0] WIN_OFF  = 2'h0;
  localparam logic [1:0] WIN_UP1  = 2'h1;
  localparam logic [1:0] WIN_UP2  = 2'h2;
  // Trigger condition codes, window mode
  localparam logic [1:0] TC_ABOVE   = 2'h0;
  localparam logic [1:0] TC_INSIDE  = 2'h1;
  localparam logic [1:0] TC_BELOW   = 2'h2;
  localparam logic [1:0] TC_OUTSIDE = 2'h3;
  // Trigger condition codes, normal mode
  localparam logic [1:0] TC_BOTH    = 2'h0;
  localparam logic [1:0] TC_RISE    = 2'h2;
  localparam logic [1:0] TC_FALL    = 2'h3;
  // Window position flag codes
  localparam logic [1:0] WP_ABOVE  = 2'h0;
  localparam logic [1:0] WP_INSIDE = 2'h1;
  localparam logic [1:0] WP_BELOW  = 2'h2;
  // Start-up time of the comparator after enable
  localparam int STARTUP_NS     = 1000;
  localparam int CLK_PERIOD_NS  = 8;
  localparam int STARTUP_CYC    = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_W      = 8;
  typedef enum logic [2:0] {
    ST_OFF   = 3'b001,
    ST_START = 3'b010,
    ST_RUN   = 3'b100
  } cowl_state_e;
endpackage : cowl_pkg

// *** core/cowl_top.sv ***
// Comparator output, window and event logic with its register file
//
// Operation
// (RULE1) Raw result one when positive above negative
// (RULE2) Pin level is result XOR inversion bit
// (RULE3) Start-up output takes the start level bit
// (RULE4) Hysteresis select drives two-bit front-end code
// (RULE5) Positive picks pins; negative also picks reference
// (RULE6) Reference equals register over 256 times Vref
// (RULE7) Power profile field trades current for speed
// (RULE8) Window partner select; zero disables window
// (RULE9) Software sets matching positive inputs, limits
// (RULE10) Window flags report above, inside, below
// (RULE11) Four window trigger conditions for irq, event
// (RULE12) Outside means above or below window
// (RULE13) Match state one when condition holds
// (RULE14) Interrupt only while enable bit set
// (RULE15) Level event follows output level; in window mode it follows the match state instead
// (RULE16) Block accepts no incoming events
// (RULE17) Software selects inputs before enabling
// (RULE18) Pin driven only when pad enable set
// (RULE19) Software configures pin as port output
// (RULE20) Code one pairs n+1, two n+2
// (RULE21) Normal mode edge select rising, falling, both
// (RULE22) Interrupt held until software clears flag
// (RULE23) Result synchronised before edge and flag logic
`timescale 1ns/100ps
`default_nettype none
module cowl_top
  import cowl_pkg::*;
(
  input  wire logic       CLOCK,
  input  wire logic       ARST_N,
  input  wire logic [2:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       CMP_RAW,
  input  wire logic       PARTNER1_RAW,
  input  wire logic       PARTNER2_RAW,
  output logic            FRONT_ENABLE,
  output logic      [1:0] HYSTERESIS_SELECT,
  output logic      [1:0] POWER_PROFILE,
  output logic      [1:0] POSITIVE_INPUT_SELECT,
  output logic      [1:0] NEGATIVE_INPUT_SELECT,
  output logic      [7:0] SCALED_REFERENCE_LEVEL,
  output logic            RUN_IN_STANDBY,
  output logic            OUT_O,
  output logic            OUT_OE,
  output logic            LEVEL_EVENT,
  output logic            IRQ
);
  import cowl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] ctrla_reg,   ctrla_next;
  logic [1:0] ctrlb_reg,   ctrlb_next;
  logic [7:0] mux_reg,     mux_next;
  logic [7:0] ref_reg,     ref_next;
  logic [1:0] mode_reg,    mode_next;
  logic       ien_reg,     ien_next;
  logic       flag_reg,    flag_next;
  logic [7:0] rdata_reg,   rdata_next;
  logic [1:0] s1_reg,      s1_next;
  logic [1:0] s2_reg,      s2_next;
  logic       s1b_reg,     s1b_next;
  logic       s2b_reg,     s2b_next;
  logic       res_reg,     res_next;
  logic       cond_reg,    cond_next;
  logic       out_reg,     out_next;
  logic       oe_reg,      oe_next;
  logic       irq_reg,     irq_next;
  logic [1:0] wpos_reg,    wpos_next;
  logic       match_reg,   match_next;
  cowl_state_e             st_reg, st_next;
  logic [STARTUP_W-1:0]    cnt_reg, cnt_next;

  logic       enabled;
  logic       win_on;
  logic       partner;
  logic       final_lvl;
  logic       event_hit;
  logic [1:0] wpos_now;
  logic       match_now;
  logic       res_sync;
  logic       part_sync;

  assign enabled = ctrla_reg[B_EN];
  assign win_on  = (ctrlb_reg == WIN_UP1) || (ctrlb_reg == WIN_UP2); // see (RULE8)
  assign res_sync  = s1b_reg;
  assign part_sync = s2b_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Register file and bus
  always_comb
  begin
    ctrla_next = ctrla_reg;
    ctrlb_next = ctrlb_reg;
    mux_next   = mux_reg;
    ref_next   = ref_reg;
    mode_next  = mode_reg;
    ien_next   = ien_reg;
    rdata_next = 8'h00;
    if (WR)
    begin
      case (ADDR)
        OFS_CTRLA:   ctrla_next = WDATA & 8'hdf;
        OFS_CTRLB:   ctrlb_next = WDATA[1:0];
        OFS_MUXCTRL: mux_next   = WDATA;
        OFS_REF:     ref_next   = WDATA; // see (RULE6)
        OFS_INTCTRL:
        begin
          mode_next = WDATA[B_MODE+:2];
          ien_next  = WDATA[B_IEN];
        end
        default:     ;
      endcase
    end
    if (RD)
    begin
      case (ADDR)
        OFS_CTRLA:   rdata_next = ctrla_reg;
        OFS_CTRLB:   rdata_next = {6'h00, ctrlb_reg};
        OFS_MUXCTRL: rdata_next = mux_reg;
        OFS_REF:     rdata_next = ref_reg;
        OFS_INTCTRL: rdata_next = {2'h0, mode_reg, 3'h0, ien_reg};
        OFS_STATUS:  rdata_next = {wpos_reg, 1'b0, match_reg, 3'h0, flag_reg};
        default:     rdata_next = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers and start-up sequence state machine
  always_comb
  begin
    s1_next  = {s1_reg[0], CMP_RAW};
    partner  = (ctrlb_reg == WIN_UP2) ? PARTNER2_RAW : PARTNER1_RAW; // see (RULE20)
    s2_next  = {s2_reg[0], partner};
    s1b_next = s1_reg[1]; // see (RULE23)
    s2b_next = s2_reg[1];
    st_next  = st_reg;
    cnt_next = cnt_reg;
    case (st_reg)
      ST_OFF:
      begin
        cnt_next = '0;
        if (enabled)
          st_next = ST_START;
      end
      ST_START:
      begin
        cnt_next = cnt_reg + 1'b1;
        if (!enabled)
          st_next = ST_OFF;
        else if (cnt_reg == STARTUP_W'(STARTUP_CYC - 1))
          st_next = ST_RUN;
      end
      ST_RUN:
      begin
        if (!enabled)
          st_next = ST_OFF;
      end
      default: st_next = ST_OFF;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output level, window position and interrupt flag
  always_comb
  begin
    // Raw input is one only for positive above negative
    // Start level pre-inverted so the pin shows it as written
    if (st_reg == ST_RUN)
      res_next = res_sync; // see (RULE1)
    else
      res_next = mux_reg[B_INIT] ^ mux_reg[B_INV]; // see (RULE3)
    final_lvl = res_reg ^ mux_reg[B_INV]; // see (RULE2)
    out_next = final_lvl;
    oe_next  = ctrla_reg[B_PADEN] && enabled; // see (RULE18)
    // Window position: comparator is upper limit, partner lower
    if (res_sync)
      wpos_now = WP_ABOVE;
    else if (part_sync)
      wpos_now = WP_INSIDE;
    else
      wpos_now = WP_BELOW; // see (RULE10)
    case (mode_reg)
      TC_ABOVE:   match_now = (wpos_now == WP_ABOVE);
      TC_INSIDE:  match_now = (wpos_now == WP_INSIDE);
      TC_BELOW:   match_now = (wpos_now == WP_BELOW);
      TC_OUTSIDE: match_now = (wpos_now != WP_INSIDE); // see (RULE12)
      default:    match_now = 1'b0;
    endcase // see (RULE11)
    wpos_next  = (win_on && st_reg == ST_RUN) ? wpos_now : WP_ABOVE;
    match_next = win_on && st_reg == ST_RUN && match_now; // see (RULE13)
    cond_next  = win_on ? match_next : final_lvl;
    if (win_on)
      event_hit = match_next && !match_reg;
    else
    begin
      case (mode_reg)
        TC_BOTH: event_hit = final_lvl != out_reg;
        TC_RISE: event_hit = final_lvl && !out_reg;
        TC_FALL: event_hit = !final_lvl && out_reg;
        default: event_hit = 1'b0;
      endcase // see (RULE21)
    end
    // Set wins over a clear in the same cycle
    flag_next = flag_reg;
    if (WR && ADDR == OFS_STATUS && WDATA[B_IF])
      flag_next = 1'b0; // see (RULE22)
    if (event_hit && st_reg == ST_RUN)
      flag_next = 1'b1;
    irq_next = flag_next && ien_next; // see (RULE14)
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers, one process per group
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ctrla_reg <= 8'h00;
      ctrlb_reg <= 2'h0;
      mux_reg   <= 8'h00;
      ref_reg   <= 8'h00;
      mode_reg  <= 2'h0;
      ien_reg   <= 1'b0;
      rdata_reg <= 8'h00;
    end
    else
    begin
      ctrla_reg <= ctrla_next;
      ctrlb_reg <= ctrlb_next;
      mux_reg   <= mux_next;
      ref_reg   <= ref_next;
      mode_reg  <= mode_next;
      ien_reg   <= ien_next;
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      s1_reg    <= 2'h0;
      s2_reg    <= 2'h0;
      s1b_reg   <= 1'b0;
      s2b_reg   <= 1'b0;
      st_reg    <= ST_OFF;
      cnt_reg   <= '0;
    end
    else
    begin
      s1_reg    <= s1_next;
      s2_reg    <= s2_next;
      s1b_reg   <= s1b_next;
      s2b_reg   <= s2b_next;
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      res_reg   <= 1'b0;
      cond_reg  <= 1'b0;
      out_reg   <= 1'b0;
      oe_reg    <= 1'b0;
      irq_reg   <= 1'b0;
      wpos_reg  <= 2'h0;
      match_reg <= 1'b0;
      flag_reg  <= 1'b0;
    end
    else
    begin
      res_reg   <= res_next;
      cond_reg  <= cond_next;
      out_reg   <= out_next;
      oe_reg    <= oe_next;
      irq_reg   <= irq_next;
      wpos_reg  <= wpos_next;
      match_reg <= match_next;
      flag_reg  <= flag_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; the block has no event input at all
  assign RDATA                  = rdata_reg;
  assign FRONT_ENABLE           = ctrla_reg[B_EN];
  assign HYSTERESIS_SELECT      = ctrla_reg[B_HYS+:2];      // see (RULE4)
  assign POWER_PROFILE          = ctrla_reg[B_PWR+:2];      // see (RULE7)
  assign POSITIVE_INPUT_SELECT  = mux_reg[B_POS+:2];        // see (RULE5)
  assign NEGATIVE_INPUT_SELECT  = mux_reg[B_NEG+:2];        // see (RULE5)
  assign SCALED_REFERENCE_LEVEL = ref_reg;                  // see (RULE6)
  assign RUN_IN_STANDBY         = ctrla_reg[B_STDBY];
  assign OUT_O                  = out_reg;
  assign OUT_OE                 = oe_reg;
  assign LEVEL_EVENT            = cond_reg;                 // see (RULE15) (RULE16)
  assign IRQ                    = irq_reg;
endmodule : cowl_top
`default_nettype wire

// *** tb/cowl_monitor.sv ***
// Port-level assertions for the comparator output logic
`timescale 1ns/100ps
`default_nettype none
module cowl_monitor
  import cowl_pkg::*;
(
  input wire logic       CLOCK,
  input wire logic       ARST_N,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       CMP_RAW,
  input wire logic       FRONT_ENABLE,
  input wire logic [1:0] HYSTERESIS_SELECT,
  input wire logic [1:0] POWER_PROFILE,
  input wire logic [1:0] POSITIVE_INPUT_SELECT,
  input wire logic [1:0] NEGATIVE_INPUT_SELECT,
  input wire logic [7:0] SCALED_REFERENCE_LEVEL,
  input wire logic       RUN_IN_STANDBY,
  input wire logic       OUT_O,
  input wire logic       OUT_OE,
  input wire logic       IRQ
);
  logic [7:0] age_reg;
  logic [7:0] age_next;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  // Cycles since enable, saturating at 200
  always_comb age_next = !FRONT_ENABLE ? 8'h00 : age_reg + 8'(age_reg != 8'hc8);
  always_ff @(posedge CLOCK or negedge ARST_N)
    if (!ARST_N) age_reg <= 8'h00;
    else age_reg <= age_next;
  sequence calm_s;
    (!WR)[*4];
  endsequence
  sequence quiet_s;
    (!WR && $stable(CMP_RAW))[*8];
  endsequence
  rdata_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data not zero outside read");
  unmapped_rd_a: assert property (RD && ADDR inside {3'h3, 3'h4}
    |=> RDATA == 8'h00) else $error("unmapped read not zero");
  ctrla_wr_a: assert property (WR && ADDR == OFS_CTRLA |=>
    {RUN_IN_STANDBY, 2'h0, POWER_PROFILE, HYSTERESIS_SELECT, FRONT_ENABLE}
    == ($past(WDATA) & 8'h9f)) else $error("control fields wrong");
  mux_wr_a: assert property (WR && ADDR == OFS_MUXCTRL |=>
    {3'h0, POSITIVE_INPUT_SELECT, 1'b0, NEGATIVE_INPUT_SELECT}
    == ($past(WDATA) & 8'h1b)) else $error("input selects wrong");
  ref_wr_a: assert property (WR && ADDR == OFS_REF |=>
    SCALED_REFERENCE_LEVEL == $past(WDATA)) else $error("reference wrong");
  oe_off_a: assert property ((!FRONT_ENABLE)[*3] |-> !OUT_OE)
    else $error("pin driven while disabled");
  startup_hold_a: assert property (calm_s ##0
    age_reg inside {[10:120]} |-> $stable(OUT_O))
    else $error("output moved during start-up");
  out_quiet_a: assert property (quiet_s ##0 age_reg == 8'hc8
    |-> $stable(OUT_O)) else $error("output moved with steady input");
  irq_hold_a: assert property ($fell(IRQ) |-> $past(WR) &&
    ($past(ADDR) == OFS_STATUS || $past(ADDR) == OFS_INTCTRL))
    else $error("interrupt dropped without a clear");
endmodule : cowl_monitor
bind cowl_top cowl_monitor mon_u (.*);
`default_nettype wire

// *** tb/test_comparator_output_window_logic.sv ***
// Self-checking bench for the comparator output logic
`timescale 1ns/100ps
`default_nettype none
module test_comparator_output_window_logic;
  import cowl_pkg::*;
  logic       clock = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic       raw = 1'b0, p1 = 1'b0, p2 = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, rv;
  logic       out_o, out_oe, lev_ev, irq;
  int         error_cnt = 0, comparisons = 0;
  always #4 clock = ~clock;
  cowl_top dut_u (.CLOCK(clock), .ARST_N(arst_n), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .CMP_RAW(raw),
    .PARTNER1_RAW(p1), .PARTNER2_RAW(p2), .FRONT_ENABLE(),
    .HYSTERESIS_SELECT(), .POWER_PROFILE(), .POSITIVE_INPUT_SELECT(),
    .NEGATIVE_INPUT_SELECT(), .SCALED_REFERENCE_LEVEL(),
    .RUN_IN_STANDBY(), .OUT_O(out_o), .OUT_OE(out_oe),
    .LEVEL_EVENT(lev_ev), .IRQ(irq));
  //////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask : rd_reg
  task automatic drv(input logic c, a, b);
    @(posedge clock);
    raw <= c;
    p1 <= a;
    p2 <= b;
    cyc(10);
  endtask : drv
  //////////////////////////////////////////////////////////////
  task automatic t_regs;
    wr_reg(OFS_CTRLA, 8'hfe);
    rd_reg(OFS_CTRLA);
    chk("ctrla", rv, 8'hde);
    chk("oe_off", out_oe, 1'b0);
    wr_reg(OFS_REF, 8'ha5);
    rd_reg(OFS_REF);
    chk("ref", rv, 8'ha5);
    wr_reg(OFS_MUXCTRL, 8'h1b);
    rd_reg(OFS_MUXCTRL);
    chk("mux", rv, 8'h1b);
    wr_reg(3'h3, 8'hff);
    rd_reg(3'h3);
    chk("unmapped", rv, 8'h00);
    wr_reg(OFS_CTRLA, 8'h00);
  endtask : t_regs
  task automatic t_start;
    wr_reg(OFS_MUXCTRL, 8'h40);
    wr_reg(OFS_CTRLA, 8'h41);
    cyc(20);
    chk("start", out_o, 1'b1);
    chk("oe_on", out_oe, 1'b1);
    cyc(150);
    chk("live", out_o, 1'b0);
    drv(1'b1, 1'b0, 1'b0);
    chk("out", out_o, 1'b1);
    chk("event", lev_ev, 1'b1);
    wr_reg(OFS_MUXCTRL, 8'hc0);
    cyc(10);
    chk("invert", out_o, 1'b0);
    chk("event_inv", lev_ev, 1'b0);
    wr_reg(OFS_CTRLA, 8'h00);
    wr_reg(OFS_CTRLA, 8'h41);
    cyc(20);
    chk("start_inv", out_o, 1'b1);
    cyc(120);
    wr_reg(OFS_MUXCTRL, 8'h00);
    wr_reg(OFS_CTRLA, 8'h01);
    cyc(3);
    chk("oe_pad", out_oe, 1'b0);
  endtask : t_start
  task automatic t_edge;
    logic [1:0] m;
    for (int i = 0; i < 4; i++)
    begin
      m = 2'(i);
      drv(1'b0, 1'b0, 1'b0);
      wr_reg(OFS_INTCTRL, {2'h0, m, 4'h1});
      wr_reg(OFS_STATUS, 8'h01);
      drv(1'b1, 1'b0, 1'b0);
      chk("irq_rise", irq, m == TC_BOTH || m == TC_RISE);
      wr_reg(OFS_STATUS, 8'h01);
      cyc(3);
      chk("irq_clr", irq, 1'b0);
      drv(1'b0, 1'b0, 1'b0);
      chk("irq_fall", irq, m == TC_BOTH || m == TC_FALL);
    end
    wr_reg(OFS_INTCTRL, 8'h00);
    wr_reg(OFS_STATUS, 8'h01);
    drv(1'b1, 1'b0, 1'b0);
    chk("irq_masked", irq, 1'b0);
    rd_reg(OFS_STATUS);
    chk("flag", rv[0], 1'b1);
  endtask : t_edge
  task automatic t_win;
    logic mt;
    wr_reg(OFS_CTRLB, 8'h01);
    for (int m = 0; m < 4; m++)
    begin
      wr_reg(OFS_INTCTRL, 8'(m << 4));
      for (int p = 0; p < 3; p++)
      begin
        drv(p == 0, p < 2, 1'b0);
        mt = m == p || (m == 3 && p != 1);
        rd_reg(OFS_STATUS);
        chk("wstat", rv & 8'hd0, {2'(p), 1'b0, mt, 4'h0});
        chk("wevent", lev_ev, mt);
      end
    end
    wr_reg(OFS_INTCTRL, {2'h0, TC_INSIDE, 4'h1});
    wr_reg(OFS_STATUS, 8'h01);
    cyc(3);
    chk("win_irq_off", irq, 1'b0);
    drv(1'b0, 1'b1, 1'b0);
    chk("win_irq", irq, 1'b1);
    wr_reg(OFS_CTRLB, 8'h02);
    drv(1'b0, 1'b0, 1'b1);
    rd_reg(OFS_STATUS);
    chk("partner2", rv & 8'hc0, 8'h40);
    wr_reg(OFS_CTRLB, 8'h00);
    rd_reg(OFS_STATUS);
    chk("win_off", rv & 8'hc0, 8'h00);
  endtask : t_win
  task automatic print_verdict;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    t_regs();
    t_start();
    t_edge();
    t_win();
    print_verdict();
  end
  initial
  begin
    #40000;
    error_cnt++;
    print_verdict();
  end
endmodule : test_comparator_output_window_logic
`default_nettype wire
